// file: exec_pkg.sv
// constants for the exchange, table, bit-move and add-with-skip unit
//
// What this block does
// [RULE1] pair exchange with memory swaps A,X with nibbles
// [RULE2] pair memory address is even, 00h to feh
// [RULE3] single exchange swaps A with one register
// [RULE4] pair exchange swaps XA with any pair
// [RULE5] page table read: DE replaces low pc bits
// [RULE6] table reads never alter the program counter
// [RULE7] page table read uses the incremented pc
// [RULE8] XA page table read behaves like DE variant
// [RULE9] absolute table read addresses with B0,C,D,E
// [RULE10] absolute table read addresses with B0,C,X,A
// [RULE11] pc and table width vary; upper bits dropped
// [RULE12] bit load copies memory bit into carry
// [RULE13] bit store writes carry, neighbours kept
// [RULE14] nibble add-with-skip skips on carry, carry kept
// [RULE15] nibble add-with-skip serves as base adjustment
// [RULE16] after carry-add, skip suppressed or instruction skipped
// [RULE17] byte add-with-skip into XA, carry kept
// [RULE18] memory add-with-skip adds (HL) to A
// [RULE19] pair add-with-skip into XA, carry kept
// [RULE20] XA added into destination pair, skip on carry
// [RULE21] skipped instruction runs as a no-operation
package exec_pkg;

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_XCH_MEM    = 4'h0,
    OP_XCH_REG    = 4'h1,
    OP_XCH_PAIR   = 4'h2,
    OP_TBL_PAGE_REL_DE_TABLE_MODE   = 4'h3,
    OP_TBL_PAGE_REL_XA_TABLE_MODE   = 4'h4,
    OP_TBL_ABSOLUTE_TABLE_MODE_A   = 4'h5,
    OP_TBL_ABSOLUTE_TABLE_MODE_B   = 4'h6,
    OP_BIT_LOAD   = 4'h7,
    OP_BIT_STORE  = 4'h8,
    OP_ADDS_N4    = 4'h9,
    OP_ADDS_N8    = 4'ha,
    OP_ADDS_HL    = 4'hb,
    OP_ADDS_XA    = 4'hc,
    OP_ADDS_DEST  = 4'hd
  } op_t;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_WAIT     = 3'b001,
    ST_CAP      = 3'b010,
    ST_WRITE    = 3'b011,
    ST_ROM_WAIT = 3'b100,
    ST_ROM_CAP  = 3'b101
  } st_t;

  // ----------------------------------------------------------------
  // register file layout, pair p holds {2p, 2p+1}
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_X = 4'h0;
  localparam logic [3:0] IDX_A = 4'h1;
  localparam logic [3:0] IDX_H = 4'h2;
  localparam logic [3:0] IDX_L = 4'h3;
  localparam logic [3:0] IDX_D = 4'h4;
  localparam logic [3:0] IDX_E = 4'h5;
  localparam logic [3:0] IDX_B = 4'h6;
  localparam logic [3:0] IDX_C = 4'h7;
  localparam int         NUM_NIB   = 16;
  localparam logic [3:0] RST_NIB   = 4'h0;
  localparam int         PC_W_DEF  = 12;
  localparam int         TAB_FULL_W = 13;
  localparam int         PAGE_LSB  = 8;
  localparam int         DM_AW     = 8;

endpackage

// file: add_skip.sv
// binary adder giving the carry out used for skip decisions
`timescale 1ns/1ns
module add_skip #(
  parameter int W = 4
) (
  // operands
  input  wire logic [W-1:0] i_a,
  input  wire logic [W-1:0] i_b,
  // result
  output logic      [W-1:0] o_sum,
  output logic              o_carry
);
  assign {o_carry, o_sum} = {1'b0, i_a} + {1'b0, i_b};
endmodule // add_skip

// file: exchange_table_bit_addskip_exec.sv
// execution unit for exchange, table read, bit move and add-with-skip
`timescale 1ns/1ns
module exchange_table_bit_addskip_exec
  import exec_pkg::*;
#(
  parameter int PC_W = PC_W_DEF
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // decoded instruction
  input  wire logic              i_op_valid,
  input  wire logic [3:0]        i_op_code,
  input  wire logic [7:0]        i_imm,
  input  wire logic [2:0]        i_reg_sel,
  input  wire logic [2:0]        i_pair_sel,
  input  wire logic [DM_AW-1:0]  i_bit_addr,
  input  wire logic [1:0]        i_bit_pos,
  input  wire logic [PC_W-1:0]   i_pc_next,
  input  wire logic              i_skip_req,
  input  wire logic              i_base_adj,
  output logic                   o_ready,
  output logic                   o_done,
  // data memory
  output logic [DM_AW-1:0]       o_dmem_addr,
  output logic                   o_dmem_rd,
  output logic                   o_dmem_we,
  output logic [3:0]             o_dmem_wdata,
  input  wire logic [3:0]        i_dmem_rdata,
  // program memory
  output logic [PC_W-1:0]        o_pmem_addr,
  output logic                   o_pmem_rd,
  input  wire logic [7:0]        i_pmem_rdata,
  // core state
  output logic                   o_carry_flag,
  output logic                   o_skip_flag,
  output logic [4*NUM_NIB-1:0]   o_reg_file
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  st_t              st_ff;
  op_t              op_ff;
  logic             half_ff;
  logic [1:0]       pos_ff;
  logic             carry_ff;
  logic             skip_ff;
  logic             done_ff;
  logic [DM_AW-1:0] dm_addr_ff;
  logic             dm_rd_ff;
  logic             dm_we_ff;
  logic [3:0]       dm_wdata_ff;
  logic [PC_W-1:0]  pm_addr_ff;
  logic             pm_rd_ff;
  logic [3:0]       reg_ff  [NUM_NIB];
  logic [3:0]       nxt_reg [NUM_NIB];

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire op_t        op_in    = op_t'(i_op_code);
  wire logic       acc      = i_op_valid && (st_ff == ST_IDLE);
  wire logic       nop      = acc && (skip_ff || i_skip_req);
  wire logic       go       = acc && !nop;
  wire logic [3:0] sel_idx  = {1'b0, i_reg_sel};
  wire logic [3:0] ph_idx   = {i_pair_sel, 1'b0};
  wire logic [3:0] pl_idx   = {i_pair_sel, 1'b1};
  wire logic [3:0] a_val    = reg_ff[IDX_A];
  wire logic [3:0] x_val    = reg_ff[IDX_X];
  wire logic [3:0] sel_val  = reg_ff[sel_idx];
  wire logic [3:0] ph_val   = reg_ff[ph_idx];
  wire logic [3:0] pl_val   = reg_ff[pl_idx];
  wire logic [7:0] xa_val   = {x_val, a_val};
  wire logic [7:0] de_val   = {reg_ff[IDX_D], reg_ff[IDX_E]};
  wire logic [7:0] hl_val   = {reg_ff[IDX_H], reg_ff[IDX_L]};
  wire logic [3:0] b_val    = reg_ff[IDX_B];
  wire logic [3:0] c_val    = reg_ff[IDX_C];
  wire logic       cap      = (st_ff == ST_CAP);

  // ----------------------------------------------------------------
  // table addresses
  // ----------------------------------------------------------------
  // incremented pc gives the next page at xxffh
  wire logic [PC_W-1:0] page_de =
    {i_pc_next[PC_W-1:PAGE_LSB], de_val};            // RULE5 RULE7
  wire logic [PC_W-1:0] page_xa =
    {i_pc_next[PC_W-1:PAGE_LSB], xa_val};            // RULE8
  wire logic [TAB_FULL_W-1:0] abs_de_full =
    {b_val[0], c_val, de_val};                       // RULE9
  wire logic [TAB_FULL_W-1:0] abs_xa_full =
    {b_val[0], c_val, xa_val};                       // RULE10
  // narrow parts simply lose the top bits
  wire logic [PC_W-1:0] abs_de = abs_de_full[PC_W-1:0];  // RULE11
  wire logic [PC_W-1:0] abs_xa = abs_xa_full[PC_W-1:0];  // RULE11
  wire logic [PC_W-1:0] tab_addr =
    (op_in == OP_TBL_PAGE_REL_DE_TABLE_MODE) ? page_de :
    (op_in == OP_TBL_PAGE_REL_XA_TABLE_MODE) ? page_xa :
    (op_in == OP_TBL_ABSOLUTE_TABLE_MODE_A) ? abs_de  : abs_xa;
  wire logic is_tbl = (op_in == OP_TBL_PAGE_REL_DE_TABLE_MODE) || (op_in == OP_TBL_PAGE_REL_XA_TABLE_MODE) ||
                      (op_in == OP_TBL_ABSOLUTE_TABLE_MODE_A) || (op_in == OP_TBL_ABSOLUTE_TABLE_MODE_B);

  // ----------------------------------------------------------------
  // data memory addresses
  // ----------------------------------------------------------------
  wire logic [DM_AW-1:0] xm_base = {i_imm[7:1], 1'b0};   // RULE2
  wire logic is_mem = (op_in == OP_XCH_MEM) || (op_in == OP_ADDS_HL) ||
                      (op_in == OP_BIT_LOAD) || (op_in == OP_BIT_STORE);
  wire logic [DM_AW-1:0] mem_addr =
    (op_in == OP_XCH_MEM) ? xm_base :
    (op_in == OP_ADDS_HL) ? hl_val  : i_bit_addr;

  // ----------------------------------------------------------------
  // adders
  // ----------------------------------------------------------------
  logic [3:0] sum4;
  logic       cy4;
  logic [7:0] sum8;
  logic       cy8;
  wire logic [3:0] add4_b = cap ? i_dmem_rdata : i_imm[3:0];
  wire logic [7:0] add8_b = (op_in == OP_ADDS_N8) ? i_imm :
                            {ph_val, pl_val};

  add_skip #(.W(4)) u_add4 (
    .i_a     (a_val),
    .i_b     (add4_b),
    .o_sum   (sum4),
    .o_carry (cy4)
  );

  add_skip #(.W(8)) u_add8 (
    .i_a     (xa_val),
    .i_b     (add8_b),
    .o_sum   (sum8),
    .o_carry (cy8)
  );

  // base adjustment: the preceding carry-add already decided the skip
  wire logic n4_skip  = cy4 && !i_base_adj;              // RULE15 RULE16
  wire logic go_skip  =
    go && (((op_in == OP_ADDS_N4) && n4_skip) ||       // RULE14
           ((op_in == OP_ADDS_N8 || op_in == OP_ADDS_XA ||
             op_in == OP_ADDS_DEST) && cy8));          // RULE17 RULE19 RULE20
  wire logic cap_skip = cap && (op_ff == OP_ADDS_HL) && cy4;  // RULE18

  // ----------------------------------------------------------------
  // register file write ports
  // ----------------------------------------------------------------
  logic [3:0] wen;
  logic [3:0] widx [4];
  logic [3:0] wdat [4];

  always_comb begin
    wen = 4'h0;
    for (int k = 0; k < 4; k++) begin
      widx[k] = IDX_X;
      wdat[k] = 4'h0;
    end
    if (go && op_in == OP_XCH_REG) begin              // RULE3
      wen = 4'h3;
      widx[0] = IDX_A;
      wdat[0] = sel_val;
      widx[1] = sel_idx;
      wdat[1] = a_val;
    end else if (go && op_in == OP_XCH_PAIR) begin    // RULE4
      wen = 4'hf;
      widx[0] = IDX_X;
      wdat[0] = ph_val;
      widx[1] = IDX_A;
      wdat[1] = pl_val;
      widx[2] = ph_idx;
      wdat[2] = x_val;
      widx[3] = pl_idx;
      wdat[3] = a_val;
    end else if (go && op_in == OP_ADDS_N4) begin     // RULE14
      wen = 4'h1;
      widx[0] = IDX_A;
      wdat[0] = sum4;
    end else if (go && (op_in == OP_ADDS_N8 ||
                        op_in == OP_ADDS_XA)) begin   // RULE17 RULE19
      wen = 4'h3;
      widx[0] = IDX_X;
      wdat[0] = sum8[7:4];
      widx[1] = IDX_A;
      wdat[1] = sum8[3:0];
    end else if (go && op_in == OP_ADDS_DEST) begin   // RULE20
      wen = 4'h3;
      widx[0] = ph_idx;
      wdat[0] = sum8[7:4];
      widx[1] = pl_idx;
      wdat[1] = sum8[3:0];
    end else if (cap && op_ff == OP_XCH_MEM) begin    // RULE1
      wen = 4'h1;
      widx[0] = half_ff ? IDX_X : IDX_A;
      wdat[0] = i_dmem_rdata;
    end else if (cap && op_ff == OP_ADDS_HL) begin    // RULE18
      wen = 4'h1;
      widx[0] = IDX_A;
      wdat[0] = sum4;
    end else if (st_ff == ST_ROM_CAP) begin           // RULE5
      wen = 4'h3;
      widx[0] = IDX_A;
      wdat[0] = i_pmem_rdata[3:0];
      widx[1] = IDX_X;
      wdat[1] = i_pmem_rdata[7:4];
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_NIB; gi++) begin : g_nib
      always_comb begin
        nxt_reg[gi] = reg_ff[gi];
        for (int k = 0; k < 4; k++) begin
          if (wen[k] && widx[k] == 4'(gi)) begin
            nxt_reg[gi] = wdat[k];
          end
        end
      end
      always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          reg_ff[gi] <= RST_NIB;
        end else begin
          reg_ff[gi] <= nxt_reg[gi];
        end
      end
      assign o_reg_file[gi*4 +: 4] = reg_ff[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // store merges the carry into the old nibble
  logic [3:0] merged;
  always_comb begin
    merged = i_dmem_rdata;
    merged[pos_ff] = carry_ff;                           // RULE13
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff       <= ST_IDLE;
      op_ff       <= OP_XCH_MEM;
      half_ff     <= 1'b0;
      pos_ff      <= 2'h0;
      carry_ff    <= 1'b0;
      skip_ff     <= 1'b0;
      done_ff     <= 1'b0;
      dm_addr_ff  <= '0;
      dm_rd_ff    <= 1'b0;
      dm_we_ff    <= 1'b0;
      dm_wdata_ff <= 4'h0;
      pm_addr_ff  <= '0;
      pm_rd_ff    <= 1'b0;
    end else begin
      done_ff  <= 1'b0;
      dm_rd_ff <= 1'b0;
      dm_we_ff <= 1'b0;
      pm_rd_ff <= 1'b0;
      if (cap_skip) begin
        skip_ff <= 1'b1;
      end else if (acc) begin
        // a pending skip is consumed by this instruction
        skip_ff <= go_skip;                              // RULE21
      end
      case (st_ff)
        ST_IDLE: begin
          if (acc) begin
            op_ff   <= op_in;
            half_ff <= 1'b0;
            pos_ff  <= i_bit_pos;
          end
          if (nop) begin
            done_ff <= 1'b1;                             // RULE21
          end else if (go && is_mem) begin
            dm_addr_ff <= mem_addr;
            dm_rd_ff   <= 1'b1;
            st_ff      <= ST_WAIT;
          end else if (go && is_tbl) begin
            // only the table address moves, never the pc
            pm_addr_ff <= tab_addr;                      // RULE6
            pm_rd_ff   <= 1'b1;
            st_ff      <= ST_ROM_WAIT;
          end else if (go) begin
            done_ff <= 1'b1;
          end
        end
        ST_WAIT: begin
          st_ff <= ST_CAP;
        end
        ST_CAP: begin
          if (op_ff == OP_XCH_MEM) begin
            dm_wdata_ff <= half_ff ? x_val : a_val;     // RULE1
            dm_we_ff    <= 1'b1;
            st_ff       <= ST_WRITE;
          end else if (op_ff == OP_BIT_STORE) begin
            dm_wdata_ff <= merged;                       // RULE13
            dm_we_ff    <= 1'b1;
            st_ff       <= ST_WRITE;
          end else begin
            if (op_ff == OP_BIT_LOAD) begin
              carry_ff <= i_dmem_rdata[pos_ff];          // RULE12
            end
            done_ff <= 1'b1;
            st_ff   <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          if (op_ff == OP_XCH_MEM && !half_ff) begin
            half_ff    <= 1'b1;
            dm_addr_ff <= {dm_addr_ff[DM_AW-1:1], 1'b1}; // RULE1
            dm_rd_ff   <= 1'b1;
            st_ff      <= ST_WAIT;
          end else begin
            done_ff <= 1'b1;
            st_ff   <= ST_IDLE;
          end
        end
        ST_ROM_WAIT: begin
          st_ff <= ST_ROM_CAP;
        end
        ST_ROM_CAP: begin
          done_ff <= 1'b1;
          st_ff   <= ST_IDLE;
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_ready      = (st_ff == ST_IDLE);
  assign o_done       = done_ff;
  assign o_dmem_addr  = dm_addr_ff;
  assign o_dmem_rd    = dm_rd_ff;
  assign o_dmem_we    = dm_we_ff;
  assign o_dmem_wdata = dm_wdata_ff;
  assign o_pmem_addr  = pm_addr_ff;
  assign o_pmem_rd    = pm_rd_ff;
  assign o_carry_flag = carry_ff;
  assign o_skip_flag  = skip_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  wire logic go_xm  = go && op_in == OP_XCH_MEM;
  wire logic is_add = op_in == OP_ADDS_N4 || op_in == OP_ADDS_N8 ||
                      op_in == OP_ADDS_XA || op_in == OP_ADDS_DEST;

  sequence s_xm_first;
    ##3 (o_dmem_we && !o_dmem_addr[0]);
  endsequence
  sequence s_xm_second;
    ##3 (o_dmem_we && o_dmem_addr[0]);
  endsequence
  property p_xch_mem;
    go_xm |-> s_xm_first ##0 s_xm_second;
  endproperty
  a_xch_mem: assert property (p_xch_mem)                // RULE1
    else $error("pair memory exchange sequence wrong");

  property p_xch_even;
    go_xm |=> (o_dmem_addr == {$past(i_imm[7:1]), 1'b0});
  endproperty
  a_xch_even: assert property (p_xch_even)              // RULE2
    else $error("pair memory address not even");

  property p_xch_reg;
    go && op_in == OP_XCH_REG |=>
      a_val == $past(sel_val) && reg_ff[$past(sel_idx)] == $past(a_val);
  endproperty
  a_xch_reg: assert property (p_xch_reg)                // RULE3
    else $error("single register exchange wrong");

  property p_tbl_page;
    go && op_in == OP_TBL_PAGE_REL_DE_TABLE_MODE |=>
      o_pmem_rd && o_pmem_addr == {$past(i_pc_next[PC_W-1:PAGE_LSB]),
                                   $past(de_val)};
  endproperty
  a_tbl_page: assert property (p_tbl_page)              // RULE7
    else $error("page table address wrong");

  property p_tbl_load;
    st_ff == ST_ROM_CAP |=> xa_val == $past(i_pmem_rdata) && o_done;
  endproperty
  a_tbl_load: assert property (p_tbl_load)              // RULE5
    else $error("table byte not loaded into XA");

  property p_bit_load;
    cap && op_ff == OP_BIT_LOAD |=>
      o_carry_flag == $past(i_dmem_rdata[pos_ff]);
  endproperty
  a_bit_load: assert property (p_bit_load)              // RULE12
    else $error("bit load did not reach carry");

  property p_bit_store;
    cap && op_ff == OP_BIT_STORE |=>
      o_dmem_we && o_dmem_wdata[$past(pos_ff)] == o_carry_flag;
  endproperty
  a_bit_store: assert property (p_bit_store)            // RULE13
    else $error("bit store wrote wrong value");

  property p_add_carry;
    go && is_add |=> $stable(o_carry_flag);
  endproperty
  a_add_carry: assert property (p_add_carry)            // RULE14
    else $error("add with skip changed carry");

  property p_n4_skip;
    go && op_in == OP_ADDS_N4 |=> o_skip_flag == $past(n4_skip);
  endproperty
  a_n4_skip: assert property (p_n4_skip)                // RULE16
    else $error("nibble add skip decision wrong");

  property p_nop;
    nop |=> $stable(o_reg_file) && $stable(o_carry_flag) &&
            !o_skip_flag && o_done && !o_dmem_we;
  endproperty
  a_nop: assert property (p_nop)                        // RULE21
    else $error("skipped instruction changed state");

endmodule // exchange_table_bit_addskip_exec

// file: mem_model.sv
// data and program memory model facing the execution unit
`timescale 1ns/1ns
module mem_model
  import exec_pkg::*;
#(
  parameter int PC_W = PC_W_DEF
) (
  // clock
  input  wire logic            i_sys_clk,
  // data memory
  input  wire logic [7:0]      i_dmem_addr,
  input  wire logic            i_dmem_rd,
  input  wire logic            i_dmem_we,
  input  wire logic [3:0]      i_dmem_wdata,
  output logic      [3:0]      o_dmem_rdata,
  // program memory
  input  wire logic [PC_W-1:0] i_pmem_addr,
  input  wire logic            i_pmem_rd,
  output logic      [7:0]      o_pmem_rdata
);
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [3:0] dmem [256];
  logic [7:0] pmem [1<<PC_W];
  logic [3:0] d_q;
  logic [7:0] p_q;
  logic [1:0] d_v = 2'h0;
  logic [1:0] p_v = 2'h0;
  initial begin
    for (int a = 0; a < 256; a++) dmem[a] = 4'(a * 7 + a / 16);
    for (int a = 0; a < (1 << PC_W); a++) pmem[a] = 8'(a * 37 + a / 256);
  end
  // ---------------------------------------------------------------
  // one-cycle synchronous access
  // ---------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    d_v <= {d_v[0], i_dmem_rd};
    p_v <= {p_v[0], i_pmem_rd};
    if (i_dmem_rd) d_q <= dmem[i_dmem_addr];
    if (i_pmem_rd) p_q <= pmem[i_pmem_addr];
    if (i_dmem_we) dmem[i_dmem_addr] <= i_dmem_wdata;
  end
  // read data is inverted two cycles after the read, so sampling two or more cycles late cannot pass by luck
  assign o_dmem_rdata = |d_v ? d_q : ~d_q;
  assign o_pmem_rdata = |p_v ? p_q : ~p_q;
endmodule // mem_model

// file: tb_top.sv
// testbench for the exchange, table, bit and add-with-skip unit
`timescale 1ns/1ns
module tb_top;
  import exec_pkg::*;
  localparam int PW = 12;
  typedef struct {
    op_t           op;
    logic [7:0]    imm;
    logic [2:0]    sel;
    logic [PW-1:0] prog_cnt;
    int            lat;
  } row_t;
  // ---------------------------------------------------------------
  // signals and expected state
  // ---------------------------------------------------------------
  logic          i_sys_clk = 1'b0;
  logic          i_rst_n = 1'b0;
  logic          i_op_valid = 1'b0;
  logic [3:0]    i_op_code = 4'h0;
  logic [7:0]    i_imm = 8'h00;
  logic [2:0]    i_reg_sel = 3'h0;
  logic [2:0]    i_pair_sel = 3'h0;
  logic [7:0]    i_bit_addr = 8'h00;
  logic [1:0]    i_bit_pos = 2'h0;
  logic [PW-1:0] i_pc_next = 12'h000;
  logic          i_skip_req = 1'b0;
  logic          i_base_adj = 1'b0;
  logic          o_ready, o_done, o_dmem_rd, o_dmem_we, o_pmem_rd;
  logic          o_carry_flag, o_skip_flag;
  logic [7:0]    o_dmem_addr, i_pmem_rdata;
  logic [3:0]    o_dmem_wdata, i_dmem_rdata;
  logic [PW-1:0] o_pmem_addr;
  logic [63:0]   o_reg_file;
  logic [3:0]    er [16] = '{default: 4'h0};
  logic [3:0]    edm [256];
  logic          ec = 1'b0;
  logic          es = 1'b0;
  logic          b2b = 1'b0;
  int            n_errors = 0;
  int            samples_checked = 0;
  row_t rows [18] = '{
    '{OP_XCH_PAIR, 8'h00, 3'h4, 12'h000, 1},
    '{OP_XCH_PAIR, 8'h00, 3'h1, 12'h000, 1},
    '{OP_XCH_PAIR, 8'h00, 3'h0, 12'h000, 1},
    '{OP_XCH_REG, 8'h00, 3'h7, 12'h000, 1},
    '{OP_XCH_REG, 8'h00, 3'h1, 12'h000, 1},
    '{OP_TBL_PAGE_REL_DE_TABLE_MODE, 8'h00, 3'h0, 12'h300, 3},
    '{OP_TBL_PAGE_REL_XA_TABLE_MODE, 8'h00, 3'h0, 12'h5ff, 3},
    '{OP_TBL_ABSOLUTE_TABLE_MODE_A, 8'h00, 3'h0, 12'h000, 3},
    '{OP_TBL_ABSOLUTE_TABLE_MODE_B, 8'h00, 3'h0, 12'h000, 3},
    '{OP_XCH_PAIR, 8'h00, 3'h6, 12'h000, 1},
    '{OP_ADDS_N8, 8'hc7, 3'h0, 12'h000, 1},
    '{OP_ADDS_XA, 8'h00, 3'h2, 12'h000, 1},
    '{OP_ADDS_DEST, 8'h00, 3'h3, 12'h000, 1},
    '{OP_ADDS_HL, 8'h00, 3'h0, 12'h000, 3},
    '{OP_ADDS_XA, 8'h00, 3'h5, 12'h000, 1},
    '{OP_XCH_MEM, 8'hfe, 3'h0, 12'h000, 7},
    '{op_t'(4'he), 8'h00, 3'h0, 12'h000, 1},
    '{OP_ADDS_DEST, 8'h00, 3'h7, 12'h000, 1}
  };
  always #4 i_sys_clk = ~i_sys_clk;
  exchange_table_bit_addskip_exec #(.PC_W(PW)) uut (
    .i_sys_clk, .i_rst_n, .i_op_valid, .i_op_code, .i_imm, .i_reg_sel,
    .i_pair_sel, .i_bit_addr, .i_bit_pos, .i_pc_next, .i_skip_req,
    .i_base_adj, .o_ready, .o_done, .o_dmem_addr, .o_dmem_rd, .o_dmem_we,
    .o_dmem_wdata, .i_dmem_rdata, .o_pmem_addr, .o_pmem_rd, .i_pmem_rdata,
    .o_carry_flag, .o_skip_flag, .o_reg_file
  );
  mem_model #(.PC_W(PW)) far (
    .i_sys_clk(i_sys_clk), .i_dmem_addr(o_dmem_addr),
    .i_dmem_rd(o_dmem_rd), .i_dmem_we(o_dmem_we),
    .i_dmem_wdata(o_dmem_wdata), .o_dmem_rdata(i_dmem_rdata),
    .i_pmem_addr(o_pmem_addr), .i_pmem_rd(o_pmem_rd),
    .o_pmem_rdata(i_pmem_rdata)
  );
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [63:0] packed_rf();
    for (int i = 0; i < 16; i++) packed_rf[4*i+:4] = er[i];
  endfunction
  task automatic check(input string nm, input logic [63:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // reference behaviour, applied before the design acts
  task automatic predict(output logic sk);
    logic [8:0] s;
    logic [12:0] ta;
    int p;
    p = 2 * i_pair_sel;
    sk = es | i_skip_req;
    es = 1'b0;
    ta = 13'h0000;
    if (!sk) begin
      case (i_op_code)
        OP_XCH_MEM: {er[0], er[1], edm[i_imm | 8'h01], edm[i_imm]} =
          {edm[i_imm | 8'h01], edm[i_imm], er[0], er[1]};
        OP_XCH_REG: {er[1], er[i_reg_sel]} = {er[i_reg_sel], er[1]};
        OP_XCH_PAIR: {er[0], er[1], er[p], er[p+1]} =
          {er[p], er[p+1], er[0], er[1]};
        OP_TBL_PAGE_REL_DE_TABLE_MODE: ta = {1'b0, i_pc_next[PW-1:8], er[4], er[5]};
        OP_TBL_PAGE_REL_XA_TABLE_MODE: ta = {1'b0, i_pc_next[PW-1:8], er[0], er[1]};
        OP_TBL_ABSOLUTE_TABLE_MODE_A: ta = {er[6][0], er[7], er[4], er[5]};
        OP_TBL_ABSOLUTE_TABLE_MODE_B: ta = {er[6][0], er[7], er[0], er[1]};
        OP_BIT_LOAD: ec = edm[i_bit_addr][i_bit_pos];
        OP_BIT_STORE: edm[i_bit_addr][i_bit_pos] = ec;
        OP_ADDS_N4, OP_ADDS_HL: begin
          s = 9'(er[1]) + 9'(i_op_code == OP_ADDS_N4 ? i_imm[3:0]
            : edm[{er[2], er[3]}]);
          er[1] = s[3:0];
          es = s[4] & ~(i_op_code == OP_ADDS_N4 && i_base_adj);
        end
        OP_ADDS_N8, OP_ADDS_XA, OP_ADDS_DEST: begin
          s = 9'({er[0], er[1]}) + (i_op_code == OP_ADDS_N8 ? 9'(i_imm)
            : 9'({er[p], er[p+1]}));
          if (i_op_code == OP_ADDS_DEST) {er[p], er[p+1]} = s[7:0];
          else {er[0], er[1]} = s[7:0];
          es = s[8];
        end
        default: ;
      endcase
      if (i_op_code inside {[OP_TBL_PAGE_REL_DE_TABLE_MODE:OP_TBL_ABSOLUTE_TABLE_MODE_B]})
        {er[0], er[1]} = far.pmem[ta[PW-1:0]];
    end
  endtask
  // offers one instruction; bit ops reuse imm and sel as address and position
  task automatic run(input row_t r);
    logic sk;
    int n;
    i_op_code = r.op;
    i_imm = r.imm;
    i_bit_addr = r.imm;
    i_reg_sel = r.sel;
    i_pair_sel = r.sel;
    i_bit_pos = r.sel[1:0];
    i_pc_next = r.prog_cnt;
    i_op_valid = 1'b1;
    predict(sk);
    @(posedge i_sys_clk);
    #1;
    if (!b2b) i_op_valid = 1'b0;
    n = 1;
    while (o_done !== 1'b1 && n < 20) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    if (!sk) check("latency", 64'(n), 64'(r.lat));
    check("regs", o_reg_file, packed_rf());
    check("carry", 64'(o_carry_flag), 64'(ec));
    check("skip", 64'(o_skip_flag), 64'(es));
    if (!b2b) begin
      // the last write lands on the same edge that raises done
      @(posedge i_sys_clk);
      #1;
      check("mem", 64'(far.dmem[i_imm]), 64'(edm[i_imm]));
      check("mem1", 64'(far.dmem[i_imm|8'h01]), 64'(edm[i_imm|8'h01]));
    end
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    #40000;
    n_errors++;
    results();
  end
  initial begin
    repeat (12) @(posedge i_sys_clk);
    #1;
    check("rst_rf", o_reg_file, 64'h0);
    check("rst_rdy", 64'(o_ready), 64'h1);
    i_rst_n = 1'b1;
    for (int a = 0; a < 256; a++) edm[a] = far.dmem[a];
    for (int r = 2; r < 8; r++) begin
      run(row_t'{OP_XCH_MEM, 8'(r * 34), 3'h0, 12'h000, 7});
      run(row_t'{OP_XCH_REG, 8'h00, 3'(r), 12'h000, 1});
    end
    foreach (rows[k]) begin
      b2b = k < 17;
      run(rows[k]);
    end
    // two adds of f always give one carry, so something is skipped
    run(row_t'{OP_ADDS_N4, 8'h0f, 3'h0, 12'h000, 1});
    run(row_t'{OP_ADDS_N4, 8'h0f, 3'h0, 12'h000, 1});
    run(row_t'{OP_XCH_REG, 8'h00, 3'h2, 12'h000, 1});
    i_base_adj = 1'b1;
    run(row_t'{OP_ADDS_N4, 8'h0f, 3'h0, 12'h000, 1});
    run(row_t'{OP_ADDS_N4, 8'h0f, 3'h0, 12'h000, 1});
    i_base_adj = 1'b0;
    i_skip_req = 1'b1;
    run(row_t'{OP_ADDS_N4, 8'h0f, 3'h0, 12'h000, 1});
    i_skip_req = 1'b0;
    for (int b = 0; b < 4; b++) begin
      run(row_t'{OP_BIT_LOAD, 8'h37, 3'(b), 12'h000, 3});
      run(row_t'{OP_BIT_STORE, 8'h90, 3'(3 - b), 12'h000, 4});
    end
    // reset in the middle of a memory exchange, after A is loaded but before any memory write
    i_op_code = OP_XCH_MEM;
    i_imm = 8'h22;
    i_op_valid = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_op_valid = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_rst_n = 1'b0;
    #1;
    check("mid_rst_rf", o_reg_file, 64'h0);
    check("mid_rst_rdy", 64'(o_ready), 64'h1);
    er = '{default: 4'h0};
    ec = 1'b0;
    es = 1'b0;
    @(posedge i_sys_clk);
    #1;
    i_rst_n = 1'b1;
    run(row_t'{OP_ADDS_N8, 8'hff, 3'h0, 12'h000, 1});
    run(row_t'{OP_XCH_MEM, 8'h22, 3'h0, 12'h000, 7});
    results();
  end
endmodule // tb_top
